//--- pkg/pda_cal_pkg.sv
package pda_cal_pkg;
  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam logic [2:0] MR_ONE    = 3'h1;
  localparam logic [2:0] MR_THREE  = 3'h3;
  localparam logic [2:0] MR_FOUR   = 3'h4;
  localparam int         PDA_BIT   = 4;
  localparam int         CAL_LSB   = 6;
  localparam int         RTTN_LSB  = 8;
  localparam int         ADDR_W    = 18;
  localparam logic [17:0] MR3_RST  = 18'h00000;
  localparam logic [17:0] MR4_RST  = 18'h00000;
  localparam logic [17:0] MR1_RST  = 18'h00000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int CAL_MIN_PS     = 3748;
  localparam int CAL_MIN_NCK    = 3;
  localparam int CAL_MIN_CYC_NS = (CAL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAL_MIN_CYC    = (CAL_MIN_CYC_NS > CAL_MIN_NCK) ? CAL_MIN_CYC_NS : CAL_MIN_NCK;
  localparam int MOD_CYC        = 24;
  localparam int CNT_W          = 6;
  localparam int STROBE_SAMPLE  = 1;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_OTHER = 3'h2
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t         kind;
    logic [2:0]        mrSel;
    logic [ADDR_W-1:0] addr;
  } cmd_t;

  function automatic logic [3:0] cal_decode(input logic [2:0] code);
    unique case (code)
      3'h0:    return 4'h0;
      3'h1:    return 4'h3;
      3'h2:    return 4'h4;
      3'h3:    return 4'h5;
      3'h4:    return 4'h6;
      3'h5:    return 4'h8;
      default: return 4'h0;
    endcase
  endfunction
endpackage

//--- logic/qualify_sampler.sv
`timescale 1ns/1ns
module qualify_sampler (
  input  wire logic sys_clk,      // clock
  input  wire logic rst,          // sync reset
  input  wire logic burstStart,   // write burst begins
  input  wire logic strobeFall,   // falling strobe edge
  input  wire logic qualifyBit,   // lane0 qualify bit
  output logic      sampleValid,  // bit captured pulse
  output logic      sampleValue   // captured bit
);
  logic armed_q, armed_d;
  logic valid_q, valid_d;
  logic value_q, value_d;

  // ----------------------------------------------------------------
  // first falling strobe edge capture
  // ----------------------------------------------------------------
  always_comb begin
    armed_d = armed_q;
    valid_d = 1'b0;
    value_d = value_q;
    if (burstStart) begin
      armed_d = 1'b1;
    end else if (armed_q && strobeFall) begin
      armed_d = 1'b0;
      valid_d = 1'b1;
      value_d = qualifyBit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armed_q <= 1'b0;
      valid_q <= 1'b0;
      value_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      valid_q <= valid_d;
      value_q <= value_d;
    end
  end

  assign sampleValid = valid_q;
  assign sampleValue = value_q;
endmodule // qualify_sampler

//--- logic/per_device_mrs_and_cs_latency.sv
`timescale 1ns/1ns
module per_device_mrs_and_cs_latency #(
  parameter int WRITE_DELAY = 20  // additive + write latency + burst/2 + delays, cycles
) (
  input  wire logic               sys_clk,      // clock
  input  wire logic               rst,          // sync reset
  input  wire logic               csActive,     // chip select asserted
  input  wire pda_cal_pkg::cmd_t  cmdIn,        // command and address bus
  input  wire logic               strobeFall,   // lower strobe falling edge
  input  wire logic               qualifyBit,   // lower byte lane0 qualify bit
  input  wire logic               geardown,     // geardown mode
  input  wire logic               termPin,      // termination pin
  output logic                    pdaMode,      // per-device mode active
  output logic [2:0]              calCode,      // latency field
  output logic [3:0]              calCycles,    // decoded latency, geardown not applied
  output logic                    rcvEnable,    // cmd/addr receivers on
  output logic                    mrsDone,      // MRS executed pulse
  output logic                    mrsDropped,   // MRS ignored pulse
  output logic                    nomTermOn,    // nominal termination on
  output logic [17:0]             mr1Value,     // mode register one
  output logic [17:0]             mr3Value      // mode register three
);
  initial begin
    if (WRITE_DELAY < 1 || WRITE_DELAY > 63) $error("WRITE_DELAY out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_QUAL = 3'b100
  } state_t;

  // ----------------------------------------------------------------
  // command latency pipeline
  // ----------------------------------------------------------------
  logic [17:0] mr1_q, mr1_d, mr3_q, mr3_d, mr4_q, mr4_d;
  logic [15:0] csPipe_q, csPipe_d;
  logic [3:0]  calEff;
  logic        cmdTake;
  logic        rcv_q, rcv_d;
  logic [3:0]  hold_q, hold_d;

  always_comb begin
    calEff = pda_cal_pkg::cal_decode(mr4_q[pda_cal_pkg::CAL_LSB +: 3]);
    if (geardown && calEff[0]) begin
      calEff = calEff + 4'h1;
    end
  end

  always_comb begin
    csPipe_d = {csPipe_q[14:0], csActive};
    cmdTake  = (calEff == 4'h0) ? csActive : csPipe_q[calEff - 4'h1];
    rcv_d    = rcv_q;
    hold_d   = hold_q;
    if (calEff == 4'h0) begin
      rcv_d = 1'b1;
    end else if (csActive) begin
      rcv_d  = 1'b1;
      hold_d = calEff;
    end else if (hold_q != 4'h0) begin
      hold_d = hold_q - 4'h1;
    end else begin
      rcv_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csPipe_q <= 16'h0000;
      rcv_q    <= 1'b1;
      hold_q   <= 4'h0;
    end else begin
      csPipe_q <= csPipe_d;
      rcv_q    <= rcv_d;
      hold_q   <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // mode registers and per-device qualification
  // ----------------------------------------------------------------
  state_t      state_q, state_d;
  logic [5:0]  wait_q, wait_d;
  pda_cal_pkg::cmd_t pend_q, pend_d;
  logic        done_q, done_d, drop_q, drop_d;
  logic        burstStart, sampleValid, sampleValue;
  logic        mrsSeen;

  assign mrsSeen = cmdTake && rcv_q && (cmdIn.kind == pda_cal_pkg::CMD_MRS);

  qualify_sampler u_sampler (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .burstStart  (burstStart),
    .strobeFall  (strobeFall),
    .qualifyBit  (qualifyBit),
    .sampleValid (sampleValid),
    .sampleValue (sampleValue)
  );

  function automatic logic [17:0] apply(input logic [17:0] cur, input logic hit, input logic [17:0] val);
    return hit ? val : cur;
  endfunction

  always_comb begin
    state_d    = state_q;
    mr1_d      = mr1_q;
    mr3_d      = mr3_q;
    mr4_d      = mr4_q;
    wait_d     = wait_q;
    pend_d     = pend_q;
    done_d     = 1'b0;
    drop_d     = 1'b0;
    burstStart = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (mrsSeen) begin
          if (mr3_q[pda_cal_pkg::PDA_BIT]) begin
            pend_d     = cmdIn;
            wait_d     = 6'(WRITE_DELAY);
            burstStart = 1'b1;
            state_d    = ST_WAIT;
          end else begin
            mr1_d  = apply(mr1_q, cmdIn.mrSel == pda_cal_pkg::MR_ONE, cmdIn.addr);
            mr3_d  = apply(mr3_q, cmdIn.mrSel == pda_cal_pkg::MR_THREE, cmdIn.addr);
            mr4_d  = apply(mr4_q, cmdIn.mrSel == pda_cal_pkg::MR_FOUR, cmdIn.addr);
            done_d = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (sampleValid) begin
          state_d = ST_QUAL;
        end else if (wait_q == 6'h00) begin
          drop_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          wait_d = wait_q - 6'h01;
        end
      end
      ST_QUAL: begin
        state_d = ST_IDLE;
        if (!sampleValue) begin
          mr1_d  = apply(mr1_q, pend_q.mrSel == pda_cal_pkg::MR_ONE, pend_q.addr);
          mr3_d  = apply(mr3_q, pend_q.mrSel == pda_cal_pkg::MR_THREE, pend_q.addr);
          mr4_d  = apply(mr4_q, pend_q.mrSel == pda_cal_pkg::MR_FOUR, pend_q.addr);
          done_d = 1'b1;
        end else begin
          drop_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      mr1_q   <= pda_cal_pkg::MR1_RST;
      mr3_q   <= pda_cal_pkg::MR3_RST;
      mr4_q   <= pda_cal_pkg::MR4_RST;
      wait_q  <= 6'h00;
      pend_q  <= '0;
      done_q  <= 1'b0;
      drop_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      mr1_q   <= mr1_d;
      mr3_q   <= mr3_d;
      mr4_q   <= mr4_d;
      wait_q  <= wait_d;
      pend_q  <= pend_d;
      done_q  <= done_d;
      drop_q  <= drop_d;
    end
  end

  // ----------------------------------------------------------------
  // termination and outputs
  // ----------------------------------------------------------------
  logic       term_q, term_d;
  logic [3:0] calCyc_q, calCyc_d;

  always_comb begin
    term_d   = (mr1_q[pda_cal_pkg::RTTN_LSB +: 3] != 3'h0) && termPin;
    calCyc_d = pda_cal_pkg::cal_decode(mr4_d[pda_cal_pkg::CAL_LSB +: 3]);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      term_q   <= 1'b0;
      calCyc_q <= 4'h0;
    end else begin
      term_q   <= term_d;
      calCyc_q <= calCyc_d;
    end
  end

  assign pdaMode    = mr3_q[pda_cal_pkg::PDA_BIT];
  assign calCode    = mr4_q[pda_cal_pkg::CAL_LSB +: 3];
  assign calCycles  = calCyc_q;
  assign rcvEnable  = rcv_q;
  assign mrsDone    = done_q;
  assign mrsDropped = drop_q;
  assign nomTermOn  = term_q;
  assign mr1Value   = mr1_q;
  assign mr3Value   = mr3_q;
endmodule // per_device_mrs_and_cs_latency

//--- dv/pda_cal_properties.sv
`timescale 1ns/1ns
module pda_cal_properties #(
  parameter int WRITE_DELAY = 20  // qualify sample timeout
) (
  input wire logic              sys_clk,    // clock
  input wire logic              rst,        // sync reset
  input wire logic              csActive,   // chip select
  input wire pda_cal_pkg::cmd_t cmdIn,      // command bus
  input wire logic              termPin,    // termination pin
  input wire logic              pdaMode,    // per-device mode
  input wire logic [2:0]        calCode,    // latency field
  input wire logic [3:0]        calCycles,  // latency cycles
  input wire logic              rcvEnable,  // receivers on
  input wire logic              mrsDone,    // executed pulse
  input wire logic              mrsDropped, // ignored pulse
  input wire logic              nomTermOn,  // nominal termination
  input wire logic [17:0]       mr1Value,   // register one
  input wire logic [17:0]       mr3Value    // register three
);
  localparam logic [3:0] LAT_TBL [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0};
  logic [2:0] rttField;
  assign rttField = mr1Value[10:8];
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_done_soon;
    ##[0:1] mrsDone;
  endsequence
  a_pda_bit_mirror: assert property (pdaMode == mr3Value[pda_cal_pkg::PDA_BIT])
    else $error("mode flag differs from register bit");
  a_pda_change_done: assert property ($changed(pdaMode) |-> s_done_soon)
    else $error("mode change without executed command");
  a_cal_decode: assert property (calCycles == LAT_TBL[calCode])
    else $error("latency decode wrong");
  a_drop_keeps_regs: assert property (mrsDropped |-> $stable(mr1Value) && $stable(mr3Value))
    else $error("ignored command changed a register");
  a_drop_in_pda: assert property (mrsDropped |-> pdaMode)
    else $error("command ignored outside per-device mode");
  a_done_pulse: assert property (mrsDone |=> !mrsDone)
    else $error("done pulse too long");
  a_mrs_done_next: assert property (csActive && cmdIn.kind == pda_cal_pkg::CMD_MRS && rcvEnable && !pdaMode
    && calCycles == 4'h0 |=> mrsDone) else $error("mode command not executed");
  a_rcv_on_cs: assert property (csActive |=> rcvEnable)
    else $error("receivers off after chip select");
  a_term_follows: assert property (1'b1 |=> nomTermOn == ($past(rttField) != 3'h0 && $past(termPin)))
    else $error("termination does not follow pin");
endmodule  // pda_cal_properties

bind per_device_mrs_and_cs_latency pda_cal_properties #(.WRITE_DELAY(WRITE_DELAY)) u_props (
  .sys_clk(sys_clk), .rst(rst), .csActive(csActive), .cmdIn(cmdIn), .termPin(termPin), .pdaMode(pdaMode),
  .calCode(calCode), .calCycles(calCycles), .rcvEnable(rcvEnable), .mrsDone(mrsDone), .mrsDropped(mrsDropped),
  .nomTermOn(nomTermOn), .mr1Value(mr1Value), .mr3Value(mr3Value)
);

//--- dv/mem_ctrl_model.sv
`timescale 1ns/1ns
module mem_ctrl_model (
  input  wire logic         sys_clk,    // clock
  input  wire logic         mrsDone,    // executed pulse
  input  wire logic         mrsDropped, // ignored pulse
  output pda_cal_pkg::cmd_t cmdIn,      // command bus
  output logic              csActive,   // chip select
  output logic              strobeFall, // strobe falling edge
  output logic              qualifyBit  // lane0 qualify bit
);
  initial begin
    cmdIn = '0;
    csActive = 1'b0;
    strobeFall = 1'b0;
    qualifyBit = 1'b1;
  end

  task automatic mrs(input logic [2:0] sel, input logic [17:0] a, input int lat, input logic pda,
                     input logic q, output logic [1:0] res);
    int i;
    res = 2'h0;
    @(posedge sys_clk);
    csActive <= 1'b1;
    for (i = 0; i < lat; i++) begin
      @(posedge sys_clk);
      csActive <= 1'b0;
    end
    cmdIn <= '{pda_cal_pkg::CMD_MRS, sel, a};
    @(posedge sys_clk);
    csActive <= 1'b0;
    cmdIn <= '{pda_cal_pkg::CMD_NOP, ~sel, ~a};
    if (pda) begin
      @(posedge sys_clk);
      strobeFall <= 1'b1;
      qualifyBit <= q;
      @(posedge sys_clk);
      strobeFall <= 1'b0;
      @(posedge sys_clk);
      qualifyBit <= ~q;
    end
    for (i = 0; i < 60 && res == 2'h0; i++) begin
      @(posedge sys_clk);
      res = {mrsDropped, mrsDone};
    end
    repeat (pda_cal_pkg::MOD_CYC + 8) @(posedge sys_clk);
  endtask
endmodule  // mem_ctrl_model

//--- dv/per_device_mrs_and_cs_latency_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errTotal++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module per_device_mrs_and_cs_latency_test;
  logic              sys_clk, rst, termPin, csActive, strobeFall, qualifyBit, geardown;
  logic              pdaMode, rcvEnable, mrsDone, mrsDropped, nomTermOn;
  logic [2:0]        calCode;
  logic [3:0]        calCycles;
  logic [17:0]       mr1Value, mr3Value;
  logic [1:0]        res;
  pda_cal_pkg::cmd_t cmdIn;
  int                errTotal = 0;
  int                cmpCount = 0;
  int                lat = 0;
  logic [3:0]        expLat [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0};

  per_device_mrs_and_cs_latency dut (
    .sys_clk(sys_clk), .rst(rst), .csActive(csActive), .cmdIn(cmdIn), .strobeFall(strobeFall),
    .qualifyBit(qualifyBit), .geardown(geardown), .termPin(termPin), .pdaMode(pdaMode), .calCode(calCode),
    .calCycles(calCycles), .rcvEnable(rcvEnable), .mrsDone(mrsDone), .mrsDropped(mrsDropped),
    .nomTermOn(nomTermOn), .mr1Value(mr1Value), .mr3Value(mr3Value));
  mem_ctrl_model ctrl (.sys_clk(sys_clk), .mrsDone(mrsDone), .mrsDropped(mrsDropped), .cmdIn(cmdIn),
    .csActive(csActive), .strobeFall(strobeFall), .qualifyBit(qualifyBit));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task finalReport;
    $display("compares %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic issue(input logic [2:0] sel, input logic [17:0] a, input logic pda, input logic q,
                       input logic [1:0] e);
    ctrl.mrs(sel, a, lat, pda, q, res);
    if (res == 2'h0) begin
      errTotal++;
      finalReport();
    end
    `CHK(res, e)
  endtask

  task test_reset;
    `CHK(pdaMode, 1'b0)
    `CHK(calCode, 3'h0)
    `CHK(rcvEnable, 1'b1)
    $display("test_reset ended");
  endtask

  task test_term;
    issue(pda_cal_pkg::MR_ONE, 18'h00100, 1'b0, 1'b0, 2'h1);
    `CHK(mr1Value, 18'h00100)
    termPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(nomTermOn, 1'b1)
    termPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(nomTermOn, 1'b0)
    $display("test_term ended");
  endtask

  task test_pda;
    issue(pda_cal_pkg::MR_THREE, 18'h00010, 1'b0, 1'b0, 2'h1);
    `CHK(pdaMode, 1'b1)
    issue(pda_cal_pkg::MR_ONE, 18'h00200, 1'b1, 1'b1, 2'h2);
    `CHK(mr1Value, 18'h00100)
    issue(pda_cal_pkg::MR_ONE, 18'h00200, 1'b1, 1'b0, 2'h1);
    `CHK(mr1Value, 18'h00200)
    termPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(nomTermOn, 1'b1)
    termPin <= 1'b0;
    issue(pda_cal_pkg::MR_THREE, 18'h00000, 1'b1, 1'b0, 2'h1);
    `CHK(pdaMode, 1'b0)
    `CHK(mr3Value, 18'h00000)
    $display("test_pda ended");
  endtask

  task test_cal;
    int k;
    for (k = 1; k <= 8; k++) begin
      issue(pda_cal_pkg::MR_FOUR, {9'h0, k[2:0], 6'h0}, 1'b0, 1'b0, 2'h1);
      lat = expLat[k[2:0]];
      `CHK(calCode, k[2:0])
      `CHK(calCycles, expLat[k[2:0]])
    end
    $display("test_cal ended");
  endtask

  task test_gear;
    geardown <= 1'b1;
    issue(pda_cal_pkg::MR_FOUR, 18'h00040, 1'b0, 1'b0, 2'h1);
    lat = 4;
    issue(pda_cal_pkg::MR_ONE, 18'h00300, 1'b0, 1'b0, 2'h1);
    `CHK(mr1Value, 18'h00300)
    `CHK(rcvEnable, 1'b0)
    issue(pda_cal_pkg::MR_FOUR, 18'h00000, 1'b0, 1'b0, 2'h1);
    lat = 0;
    geardown <= 1'b0;
    `CHK(calCycles, 4'h0)
    $display("test_gear ended");
  endtask

  initial begin
    rst = 1'b1;
    termPin = 1'b0;
    geardown = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    test_reset();
    test_term();
    test_pda();
    test_cal();
    test_gear();
    finalReport();
  end
endmodule  // per_device_mrs_and_cs_latency_test
